// ### adsq_defines.svh
`ifndef ADSQ_DEFINES_SVH
`define ADSQ_DEFINES_SVH
// ==========================================
// register offsets
`define ADSQ_OFS_CTRL 8'h00
`define ADSQ_OFS_MODE 8'h04
`define ADSQ_OFS_CHEN 8'h10
`define ADSQ_OFS_CHDIS 8'h14
`define ADSQ_OFS_CHST 8'h18
`define ADSQ_OFS_STAT 8'h1c
`define ADSQ_OFS_LAST 8'h20
`define ADSQ_OFS_IEN 8'h24
`define ADSQ_OFS_IDIS 8'h28
`define ADSQ_OFS_IMSK 8'h2c
`define ADSQ_OFS_CDR0 8'h30
`define ADSQ_OFS_RCR 8'h80
`define ADSQ_OFS_RNCR 8'h84
// ==========================================
// field positions
`define ADSQ_CR_SRST 0
`define ADSQ_CR_START 1
`define ADSQ_MR_HW_TRIGGER_ENABLE 0
`define ADSQ_MR_TSEL_LO 1
`define ADSQ_MR_LOW_RESOLUTION 4
`define ADSQ_MR_SLEEP 5
`define ADSQ_MR_PRE_LO 8
`define ADSQ_MR_SU_LO 16
`define ADSQ_MR_SH_LO 24
`define ADSQ_SR_OVRE_LO 8
`define ADSQ_SR_RESULT_READY 16
`define ADSQ_SR_GENERAL_OVERRUN 17
`define ADSQ_SR_RECEIVE_COUNT_DONE 18
`define ADSQ_SR_RECEIVE_BUFFERS_FULL 19
// ==========================================
// masks, reset values, codes
`define ADSQ_MR_MASK 32'h0f7fff3f
`define ADSQ_SR_MASK 32'h000f0f0f
`define ADSQ_MR_RESET 32'h00000000
`define ADSQ_RECEIVE_COUNT_DONE_RESET 1'b1
`define ADSQ_TSEL_EXT 3'h6
`define ADSQ_WARM_MULT 11'h008
`define ADSQ_RESP_OK 2'h0
`define ADSQ_RESP_ERR 2'h2
`endif

// ### adsq_pkg.sv
`default_nettype none
package adsq_pkg;
  typedef enum logic [1:0] {S_IDLE, S_WARM, S_HOLD, S_CONV} adsq_state_t;
  typedef logic [9:0] adsq_data_t;
endpackage : adsq_pkg
`default_nettype wire

// ### adsq_div_if.sv
`default_nettype none
interface adsq_div_if;
  logic [7:0] divider;
  logic tick;
  logic clk_lvl;
  modport ctrl (output divider, input tick, input clk_lvl);
  modport gen (input divider, output tick, output clk_lvl);
endinterface : adsq_div_if
`default_nettype wire

// ### adsq_clk_div.sv
`default_nettype none
module adsq_clk_div #(
  parameter int DIV_W = 8
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic srst,
  // divider link
  adsq_div_if.gen dv
);
  // ==========================================
  // parameter check
  if (DIV_W != 8) begin : g_chk
    $error("adsq_clk_div: divider width must be 8");
  end

  logic [DIV_W-1:0] cnt_r;
  logic lvl_r;
  logic tick_r;

  // ==========================================
  // half period of divider+1 master clocks
  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      cnt_r <= '0;
      lvl_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (cnt_r == dv.divider) begin
        cnt_r <= '0;
        lvl_r <= ~lvl_r;
        tick_r <= ~lvl_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign dv.tick = tick_r;
  assign dv.clk_lvl = lvl_r;

  tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_r && !srst |=> !tick_r) else $error("converter tick repeated");
endmodule : adsq_clk_div
`default_nettype wire

// ### adsq_seq_top.sv
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "adsq_defines.svh"
`default_nettype none
module adsq_seq_top
  import adsq_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // triggers
  input wire logic [2:0] timer_trig,
  input wire logic ext_trig,
  // analog cell
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic cell_power,
  output logic conv_start,
  output logic [1:0] chan_sel,
  output logic conv_clk,
  // transfer counters
  input wire logic rx_xfer
);
  // ==========================================
  // parameter check
  if (ADDR_W != 8 || NCH != 4) begin : g_chk
    $error("adsq_seq_top: address width 8 and four channels only");
  end

  // ==========================================
  // functions
  function automatic logic [31:0] bmask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : bmask

  function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : next_ch

  function automatic logic trig_pick(input logic [2:0] sel, input logic [2:0] tm, input logic ex);
    logic t;
    t = 1'b0;
    if (sel < 3'h3) begin
      t = tm[sel[1:0]];
    end else if (sel == `ADSQ_TSEL_EXT) begin
      t = ex;
    end
    return t;
  endfunction : trig_pick

  // ==========================================
  // bus slave
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_nxt, wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] waddr_r;
  logic aw_got_r, w_got_r, wr_fire, rd_fire, rd_ok;
  logic [31:0] wd;

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign rd_fire = arvalid && arready_r;
  assign wd = wdata_r & bmask(wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `ADSQ_RESP_OK;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (awvalid && awready_r) begin
        waddr_r <= awaddr;
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (waddr_r[1:0] == 2'h0 && waddr_r <= `ADSQ_OFS_RNCR) ? `ADSQ_RESP_OK : `ADSQ_RESP_ERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `ADSQ_RESP_OK;
    end else begin
      if (rd_fire) begin
        rdata_r <= rd_nxt;
        rresp_r <= rd_ok ? `ADSQ_RESP_OK : `ADSQ_RESP_ERR;
        rvalid_r <= 1'b1;
        arready_r <= 1'b0;
      end
      if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ==========================================
  // write and read strobes
  logic srst, sw_start, wr_mode, wr_rcr, wr_rncr, rd_stat, rd_last;
  assign srst = wr_fire && waddr_r == `ADSQ_OFS_CTRL && wd[`ADSQ_CR_SRST];
  assign sw_start = wr_fire && waddr_r == `ADSQ_OFS_CTRL && wd[`ADSQ_CR_START] && !srst;
  assign wr_mode = wr_fire && waddr_r == `ADSQ_OFS_MODE;
  assign wr_rcr = wr_fire && waddr_r == `ADSQ_OFS_RCR;
  assign wr_rncr = wr_fire && waddr_r == `ADSQ_OFS_RNCR;
  assign rd_stat = rd_fire && araddr == `ADSQ_OFS_STAT;
  assign rd_last = rd_fire && araddr == `ADSQ_OFS_LAST;

  // ==========================================
  // mode, channel enables, mask
  logic [31:0] mode_r, mask_r;
  logic [3:0] chan_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      mode_r <= `ADSQ_MR_RESET;
    end else if (wr_mode) begin
      mode_r <= (mode_r & ~bmask(wstrb_r)) | (wd & `ADSQ_MR_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      chan_en_r <= '0;
    end else if (wr_fire && waddr_r == `ADSQ_OFS_CHEN) begin
      chan_en_r <= chan_en_r | wd[3:0];
    end else if (wr_fire && waddr_r == `ADSQ_OFS_CHDIS) begin
      chan_en_r <= chan_en_r & ~wd[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      mask_r <= '0;
    end else if (wr_fire && waddr_r == `ADSQ_OFS_IEN) begin
      mask_r <= mask_r | (wd & `ADSQ_SR_MASK);
    end else if (wr_fire && waddr_r == `ADSQ_OFS_IDIS) begin
      mask_r <= mask_r & ~wd;
    end
  end

  logic hw_en, low_resolution, sleep;
  logic [2:0] tsel;
  logic [6:0] su_fld;
  logic [3:0] sh_fld;
  assign hw_en = mode_r[`ADSQ_MR_HW_TRIGGER_ENABLE];
  assign tsel = mode_r[`ADSQ_MR_TSEL_LO +: 3];
  assign low_resolution = mode_r[`ADSQ_MR_LOW_RESOLUTION];
  assign sleep = mode_r[`ADSQ_MR_SLEEP];
  assign su_fld = mode_r[`ADSQ_MR_SU_LO +: 7];
  assign sh_fld = mode_r[`ADSQ_MR_SH_LO +: 4];

  // ==========================================
  // converter clock
  adsq_div_if dv ();
  assign dv.divider = mode_r[`ADSQ_MR_PRE_LO +: 8];
  adsq_clk_div #(.DIV_W(8)) adsq_clk_div_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .srst(srst),
    .dv(dv.gen)
  );

  // ==========================================
  // trigger edge
  logic trig_cur, trig_prev_r, hw_edge, go;
  assign trig_cur = trig_pick(tsel, timer_trig, ext_trig);
  assign hw_edge = hw_en && trig_cur && !trig_prev_r;
  assign go = sw_start || hw_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_cur;
    end
  end

  // ==========================================
  // sequencer
  adsq_state_t state_r;
  logic [10:0] cnt_r;
  logic [1:0] cur_ch_r, last_ch_r;
  logic power_r, warm_r, start_r, done_evt;
  logic [2:0] first_ch, nxt_ch;
  assign first_ch = next_ch(chan_en_r, 3'h0);
  assign nxt_ch = next_ch(chan_en_r, {1'b0, cur_ch_r} + 3'h1);
  assign done_evt = state_r == S_CONV && conv_done;

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      cur_ch_r <= '0;
      last_ch_r <= '0;
      power_r <= 1'b0;
      warm_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (go && first_ch[2]) begin
            power_r <= 1'b1;
            cur_ch_r <= first_ch[1:0];
            if (warm_r) begin
              state_r <= S_HOLD;
              cnt_r <= {7'h00, sh_fld};
            end else begin
              state_r <= S_WARM;
              cnt_r <= ({4'h0, su_fld} + 11'h001) * `ADSQ_WARM_MULT - 11'h001;
            end
          end else begin
            power_r <= !sleep;
            warm_r <= warm_r && !sleep;
          end
        end
        S_WARM: begin
          if (dv.tick) begin
            if (cnt_r == '0) begin
              warm_r <= 1'b1;
              state_r <= S_HOLD;
              cnt_r <= {7'h00, sh_fld};
            end else begin
              cnt_r <= cnt_r - 11'h001;
            end
          end
        end
        S_HOLD: begin
          if (dv.tick) begin
            if (cnt_r == '0) begin
              start_r <= 1'b1;
              state_r <= S_CONV;
            end else begin
              cnt_r <= cnt_r - 11'h001;
            end
          end
        end
        S_CONV: begin
          if (conv_done) begin
            last_ch_r <= cur_ch_r;
            if (nxt_ch[2]) begin
              cur_ch_r <= nxt_ch[1:0];
              state_r <= S_HOLD;
              cnt_r <= {7'h00, sh_fld};
            end else begin
              state_r <= S_IDLE;
              power_r <= !sleep;
              warm_r <= !sleep;
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // results and flags
  adsq_data_t res, last_r;
  adsq_data_t cdr_r [NCH];
  logic [3:0] eoc_r, ovre_r;
  logic result_ready_r, general_overrun_r;
  assign res = low_resolution ? {2'h0, conv_data[9:2]} : conv_data;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic hit, rd_cdr;
    assign hit = done_evt && cur_ch_r == 2'(g) && chan_en_r[g];
    assign rd_cdr = rd_fire && araddr == 8'(`ADSQ_OFS_CDR0 + 4 * g);
    always_ff @(posedge aclk) begin
      if (!aresetn || srst) begin
        eoc_r[g] <= 1'b0;
      end else if (hit) begin
        eoc_r[g] <= 1'b1;
      end else if (rd_cdr || (rd_last && last_ch_r == 2'(g))) begin
        eoc_r[g] <= 1'b0;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || srst) begin
        ovre_r[g] <= 1'b0;
      end else if (hit && eoc_r[g]) begin
        ovre_r[g] <= 1'b1;
      end else if (rd_stat) begin
        ovre_r[g] <= 1'b0;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || srst) begin
        cdr_r[g] <= '0;
      end else if (hit) begin
        cdr_r[g] <= res;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      result_ready_r <= 1'b0;
      general_overrun_r <= 1'b0;
      last_r <= '0;
    end else begin
      if (done_evt) begin
        result_ready_r <= 1'b1;
        last_r <= res;
      end else if (rd_last) begin
        result_ready_r <= 1'b0;
      end
      if (done_evt && result_ready_r) begin
        general_overrun_r <= 1'b1;
      end else if (rd_stat) begin
        general_overrun_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // receive counters
  logic [15:0] rcr_r, rncr_r;
  logic receive_count_done_r, receive_buffers_full;
  assign receive_buffers_full = rcr_r == '0 && rncr_r == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      rcr_r <= '0;
      rncr_r <= '0;
    end else begin
      if (wr_rcr) begin
        rcr_r <= wd[15:0];
      end else if (rx_xfer && rcr_r != '0) begin
        if (rcr_r == 16'h0001 && rncr_r != '0) begin
          rcr_r <= rncr_r;
          rncr_r <= '0;
        end else begin
          rcr_r <= rcr_r - 16'h0001;
        end
      end
      if (wr_rncr) begin
        rncr_r <= wd[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || srst) begin
      receive_count_done_r <= `ADSQ_RECEIVE_COUNT_DONE_RESET;
    end else if (rx_xfer && !wr_rcr && rcr_r == 16'h0001) begin
      receive_count_done_r <= 1'b1;
    end else if (wr_rcr || wr_rncr) begin
      receive_count_done_r <= 1'b0;
    end
  end

  // ==========================================
  // read mux
  always_comb begin
    rd_nxt = '0;
    rd_ok = 1'b1;
    case (araddr)
      `ADSQ_OFS_MODE: rd_nxt = mode_r;
      `ADSQ_OFS_CHST: rd_nxt = {28'h0, chan_en_r};
      `ADSQ_OFS_STAT: rd_nxt = {12'h0, receive_buffers_full, receive_count_done_r, general_overrun_r, result_ready_r, 4'h0, ovre_r, 4'h0, eoc_r & chan_en_r};
      `ADSQ_OFS_LAST: rd_nxt = {22'h0, last_r};
      `ADSQ_OFS_IMSK: rd_nxt = mask_r;
      `ADSQ_OFS_CDR0: rd_nxt = {22'h0, cdr_r[0]};
      8'h34: rd_nxt = {22'h0, cdr_r[1]};
      8'h38: rd_nxt = {22'h0, cdr_r[2]};
      8'h3c: rd_nxt = {22'h0, cdr_r[3]};
      `ADSQ_OFS_RCR: rd_nxt = {16'h0, rcr_r};
      `ADSQ_OFS_RNCR: rd_nxt = {16'h0, rncr_r};
      `ADSQ_OFS_CTRL, `ADSQ_OFS_CHEN, `ADSQ_OFS_CHDIS, `ADSQ_OFS_IEN, `ADSQ_OFS_IDIS: rd_nxt = '0;
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================
  // outputs
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign cell_power = power_r;
  assign conv_start = start_r;
  assign chan_sel = cur_ch_r;
  assign conv_clk = dv.clk_lvl;

  // ==========================================
  // checks
  soft_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    srst |=> mode_r == '0 && chan_en_r == '0 && mask_r == '0 && state_r == S_IDLE && !result_ready_r)
    else $error("soft reset did not clear block");
  sw_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_start && state_r == S_IDLE && chan_en_r != '0 |=> state_r != S_IDLE && power_r)
    else $error("software start ignored");
  no_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == S_IDLE && !hw_en && !sw_start |=> state_r == S_IDLE)
    else $error("sequence began without start");
  rsvd_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tsel inside {3'h3, 3'h4, 3'h5, 3'h7} |-> !hw_edge)
    else $error("reserved select produced trigger");
  ovre_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_evt && !srst && chan_en_r[cur_ch_r] && eoc_r[cur_ch_r] |=> ovre_r[$past(cur_ch_r)])
    else $error("channel overrun missed");
  general_overrun_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_evt && result_ready_r && !srst |=> general_overrun_r && result_ready_r)
    else $error("general overrun missed");
  stat_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_stat && !done_evt ##1 !done_evt |-> ovre_r == '0 && !general_overrun_r)
    else $error("status read kept overrun");
  last_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done_evt && !srst |=> last_r == $past(res) && result_ready_r)
    else $error("last result not captured");
  mask_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && waddr_r == `ADSQ_OFS_IEN && !srst |=> (mask_r & $past(wd) & `ADSQ_SR_MASK) == ($past(wd) & `ADSQ_SR_MASK))
    else $error("irq enable not applied");
  hold_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == S_HOLD && dv.tick && cnt_r == '0 && !srst |=> state_r == S_CONV && start_r)
    else $error("hold end did not start conversion");
endmodule : adsq_seq_top
`default_nettype wire

// ### adsq_cell_model.sv
`default_nettype none
// ==========================================
// analog cell stand-in
module adsq_cell_model #(
  parameter int LAT = 3
) (
  // clock
  input wire logic aclk,
  // cell link
  input wire logic cell_power,
  input wire logic conv_start,
  input wire logic [1:0] chan_sel,
  output logic conv_done,
  output logic [9:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [1:0] ch = 2'h0;
  initial conv_done = 1'b0;
  initial conv_data = 10'h000;
  // data line flips outside the result cycle
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start && cell_power) begin
      cnt <= LAT;
      ch <= chan_sel;
    end else if (cnt == 1) begin
      conv_done <= 1'b1;
      conv_data <= {ch, 6'h2b, ch};
    end
    if (cnt > 0 && !conv_start) cnt <= cnt - 1;
  end
endmodule : adsq_cell_model
`default_nettype wire

// ### adsq_seq_top_tb.sv
`default_nettype none
module adsq_seq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic ext_trig = 1'b0;
  logic rx_xfer = 1'b0;
  logic [2:0] timer_trig = 3'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, conv_done, cell_power, conv_start, conv_clk;
  logic [1:0] bresp, rresp, chan_sel, bres, rr;
  logic [9:0] conv_data;
  logic [31:0] rdata, rv, per, tr;
  logic [31:0] tm [6] = '{32'h1, 32'h3, 32'h5, 32'hd, 32'h7, 32'h0};
  logic [3:0] tg [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf, 4'hf};
  int n_fail = 0;
  int tests_run = 0;
  int ndone = 0;
  int n, n0;
  // ==========================================
  // design and cell
  adsq_seq_top adsq_seq_top_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .timer_trig(timer_trig), .ext_trig(ext_trig),
    .conv_done(conv_done), .conv_data(conv_data), .cell_power(cell_power), .conv_start(conv_start),
    .chan_sel(chan_sel), .conv_clk(conv_clk), .rx_xfer(rx_xfer)
  );
  adsq_cell_model #(.LAT(5)) adsq_cell_model_i (
    .aclk(aclk), .cell_power(cell_power), .conv_start(conv_start), .chan_sel(chan_sel),
    .conv_done(conv_done), .conv_data(conv_data)
  );
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) if (conv_done === 1'b1) ndone <= ndone + 1;
  always @(posedge conv_clk) begin
    per <= 32'($time) - tr;
    tr <= 32'($time);
  end
  // ==========================================
  // checking and bus tasks
  function automatic logic [31:0] cv(input logic [1:0] c);
    return {22'h0, c, 6'h2b, c};
  endfunction : cv
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic lim;
    if (n >= 300) begin
      n_fail++;
      complete_run();
    end
  endtask : lim
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 300);
    bres = bresp;
    lim();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 300);
    rv = rdata;
    rr = rresp;
    lim();
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rv, e);
  endtask : rc
  task automatic wdone(input int k);
    n = 0;
    while (ndone < k && n < 300) begin
      @(posedge aclk);
      n++;
    end
    lim();
  endtask : wdone
  // ==========================================
  // scenarios
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(8'h04, 32'h0, "mode");
    rc(8'h1c, 32'h000c0000, "status");
    wr(8'h10, 32'hb);
    rc(8'h18, 32'hb, "chan");
    wr(8'h14, 32'h8);
    rc(8'h18, 32'h3, "chan");
    wr(8'h24, 32'hffffffff);
    rc(8'h2c, 32'h000f0f0f, "mask");
    wr(8'h28, 32'h00050a05);
    rc(8'h2c, 32'h000a050a, "mask");
    wr(8'h00, 32'h2);
    wdone(2);
    rc(8'h1c, 32'h000f0003, "status");
    rc(8'h30, cv(0), "data0");
    rc(8'h34, cv(1), "data1");
    rc(8'h1c, 32'h000d0000, "status");
    rc(8'h20, cv(1), "last");
    rc(8'h1c, 32'h000c0000, "status");
    chk("power", 32'(cell_power), 32'h1);
    repeat (2) begin
      n0 = ndone;
      wr(8'h00, 32'h2);
      wdone(n0 + 2);
    end
    rc(8'h1c, 32'h000f0303, "status");
    rc(8'h1c, 32'h000d0003, "status");
    rd(8'h30);
    rd(8'h20);
    wr(8'h04, 32'h10);
    n0 = ndone;
    wr(8'h00, 32'h2);
    wdone(n0 + 2);
    rc(8'h30, cv(0) >> 2, "data0 low");
    rc(8'h20, cv(1) >> 2, "last low");
    rc(8'h1c, 32'h000e0000, "status");
    wr(8'h14, 32'h1); // idle
    for (int i = 0; i < 6; i++) begin
      wr(8'h04, tm[i]);
      {ext_trig, timer_trig} <= tg[i];
      @(posedge aclk);
      {ext_trig, timer_trig} <= 4'h0;
      repeat (100) @(posedge aclk);
      rc(8'h1c, (i < 4) ? 32'h000d0002 : 32'h000c0000, "trigger");
      rd(8'h20);
    end
    wr(8'h04, 32'h02000120);
    n0 = ndone;
    wr(8'h00, 32'h2);
    n = 0;
    while (conv_start !== 1'b1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    lim();
    chk("start delay", 32'(n >= 38 && n <= 48), 32'h1);
    chk("power", 32'(cell_power), 32'h1);
    chk("clk period", per, 32'd400);
    wdone(n0 + 1);
    repeat (2) @(posedge aclk);
    chk("power", 32'(cell_power), 32'h0);
    rc(8'h20, cv(1), "last");
    wr(8'h00, 32'h3);
    n0 = ndone;
    rc(8'h04, 32'h0, "mode");
    rc(8'h18, 32'h0, "chan");
    rc(8'h2c, 32'h0, "mask");
    repeat (50) @(posedge aclk);
    chk("no start", 32'(ndone), 32'(n0));
    wr(8'h80, 32'h2);
    rc(8'h1c, 32'h0, "status");
    repeat (2) begin
      rx_xfer <= 1'b1;
      @(posedge aclk);
      rx_xfer <= 1'b0;
      @(posedge aclk);
    end
    rc(8'h1c, 32'h000c0000, "status");
    rd(8'h44);
    chk("read resp", 32'(rr), 32'h2);
    wr(8'h88, 32'h1);
    chk("write resp", 32'(bres), 32'h2);
    complete_run();
  end
endmodule : adsq_seq_top_tb
`default_nettype wire
